// ===== hw/twm_timer.sv
/*
  twm_timer: 8-bit timer with clear-on-match, fast PWM and phase-correct
  PWM waveform modes, two compare outputs, AXI4-Lite register slave.
  Assumes: single clock, bus master per AXI4-Lite, pin direction bits set
  by software before the pins are expected to show the waveform.
*/
// The implementer's own choices: the address map and the AXI4-Lite register port.
// Behaviour
// - mode 2 clears count at compare A
// - unbuffered compare A may be missed, wraps
// - compare A flag at top in mode 2
// - action 1 toggles output A in mode 2
// - overflow when count passes max to zero
// - fast PWM counts up, top max or A
// - fast PWM clears at tick after top
// - fast PWM clear/set on match, bottom
// - fast PWM overflow at top
// - fast PWM toggle A only, high bit
// - fast PWM extremes: spike or constant
// - fast PWM compares buffered, toggle too
// - phase PWM counts up then down
// - phase PWM holds top one tick
// - phase PWM up/down match actions
// - phase PWM overflow at bottom
// - phase PWM toggle A only, high bit
// - phase PWM extremes give constant levels
// - leaving max keeps bottom symmetry; the code holds the down-match level at that top (old max compare)
// - missed up-match still switches output
// - buffered in PWM, direct otherwise
// - action zero leaves output unchanged
// - match sets compare flag next tick
// - output registers reset to zero
`timescale 1ns/1ps
module twm_timer (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // register bus
  input  wire twm_pkg::twm_axi_req_t axi_req,
  output twm_pkg::twm_axi_rsp_t      axi_rsp,
  // waveform outputs
  output logic                       wave_out_a,
  output logic                       wave_out_b,
  output logic                       wave_out_a_pin,
  output logic                       wave_out_a_pin_oe,
  output logic                       wave_out_b_pin,
  output logic                       wave_out_b_pin_oe,
  // event flags
  output logic                       overflow_flag,
  output logic                       compare_a_flag
);
  import twm_pkg::*;

  twm_state_t st;
  twm_state_t next_st;

  logic       tick;
  logic       is_fast;
  logic       is_phase;
  logic       is_pwm;
  logic [7:0] top;
  logic       at_top;
  logic       match_a;
  logic       match_b;
  logic       wr_go;
  logic       rd_go;
  logic       wr_hit;
  logic       rd_hit;
  logic [DATA_W-1:0] rd_word;
  logic       conn_a;
  logic       conn_b;

  // next level of one compare output
  function automatic logic wave_next(
    input logic       cur,
    input logic [1:0] act,
    input logic       is_a,
    input logic       hit,
    input logic [7:0] cmp,
    input logic [2:0] mode,
    input logic [7:0] count,
    input logic       up,
    input logic [7:0] top_v,
    input logic       tk
  );
    logic res;
    logic up_res;
    logic dn_res;
    res    = cur;
    up_res = act[0];
    dn_res = ~act[0];
    if (act == ACT_OFF) begin
      res = cur;
    end else if (mode == MODE_FAST_MAX || mode == MODE_FAST_CMP) begin
      if (act == ACT_TOGGLE) begin
        if (is_a && mode[MODE_HIGH_BIT] && hit)
          res = ~cur;
      end else begin
        // match at top ignored: only the bottom action remains
        if (hit && cmp != top_v)
          res = act[0];
        if (tk && count == top_v)
          res = ~act[0];
      end
    end else if (mode == MODE_PHASE_MAX || mode == MODE_PHASE_CMP) begin
      if (act == ACT_TOGGLE) begin
        if (is_a && mode[MODE_HIGH_BIT] && hit)
          res = ~cur;
      end else if (tk) begin
        if (count == top_v && cmp == top_v)
          res = dn_res;
        else if (count == COUNT_BOTTOM)
          // restore the level the up slope starts from
          res = (cmp == COUNT_BOTTOM) ? up_res : dn_res;
        else if (up && count >= cmp && cmp != top_v)
          res = up_res;
        else if (!up && hit)
          res = dn_res;
      end
    end else if (hit) begin
      case (act)
        ACT_TOGGLE: res = ~cur;
        ACT_CLEAR:  res = 1'b0;
        ACT_SET:    res = 1'b1;
        default:    res = cur;
      endcase
    end
    return res;
  endfunction

  // mode decode and timer clock enable
  always_comb begin
    is_fast  = (st.mode == MODE_FAST_MAX) || (st.mode == MODE_FAST_CMP);
    is_phase = (st.mode == MODE_PHASE_MAX) || (st.mode == MODE_PHASE_CMP);
    is_pwm   = is_fast || is_phase;
    top      = (st.mode == MODE_CTC || st.mode == MODE_PHASE_CMP ||
                st.mode == MODE_FAST_CMP) ? st.cmp_a : COUNT_MAX;
    tick     = st.run && (st.div == st.presc);
    at_top   = (st.count == top);
    // a count write masks matches for one tick
    match_a  = tick && !st.block && (st.count == st.cmp_a);
    match_b  = tick && !st.block && (st.count == st.cmp_b);
  end

  // bus decode
  always_comb begin
    wr_go  = axi_req.awvalid && axi_req.wvalid && !st.bvalid;
    rd_go  = axi_req.arvalid && !st.rvalid;
    wr_hit = (axi_req.awaddr == ADDR_CTRL) || (axi_req.awaddr == ADDR_CMPA) ||
             (axi_req.awaddr == ADDR_CMPB) || (axi_req.awaddr == ADDR_COUNT) ||
             (axi_req.awaddr == ADDR_FLAGS) || (axi_req.awaddr == ADDR_PRESC);
    rd_hit = 1'b1;
    rd_word = '0;
    case (axi_req.araddr)
      ADDR_CTRL: begin
        rd_word[CTRL_MODE_LSB +: 3] = st.mode;
        rd_word[CTRL_RUN]           = st.run;
        rd_word[CTRL_ACTB_LSB +: 2] = st.act_b;
        rd_word[CTRL_ACTA_LSB +: 2] = st.act_a;
        rd_word[CTRL_DIRA]          = st.dir_a;
        rd_word[CTRL_DIRB]          = st.dir_b;
      end
      ADDR_CMPA:  rd_word[7:0] = st.cmp_a_buf;
      ADDR_CMPB:  rd_word[7:0] = st.cmp_b_buf;
      ADDR_COUNT: rd_word[7:0] = st.count;
      ADDR_FLAGS: begin
        rd_word[FLAG_OVF]  = st.ovf;
        rd_word[FLAG_CMPA] = st.flag_a;
        rd_word[FLAG_CMPB] = st.flag_b;
      end
      ADDR_PRESC: rd_word[7:0] = st.presc;
      default:    rd_hit = 1'b0;
    endcase
  end

  // next state
  always_comb begin
    next_st = st;
    // timer clock enable divider
    if (!st.run || tick)
      next_st.div = PRESC_RESET;
    else
      next_st.div = st.div + COUNT_ONE;
    if (tick) begin
      next_st.block = 1'b0;
      case (st.mode)
        MODE_CTC: begin
          // compare A unbuffered: a missed match runs on to max and wraps
          next_st.count = at_top ? COUNT_BOTTOM : st.count + COUNT_ONE;
        end
        MODE_FAST_MAX, MODE_FAST_CMP: begin
          if (at_top) begin
            next_st.count = COUNT_BOTTOM;
            next_st.cmp_a = st.cmp_a_buf;
            next_st.cmp_b = st.cmp_b_buf;
          end else begin
            next_st.count = st.count + COUNT_ONE;
          end
        end
        MODE_PHASE_MAX, MODE_PHASE_CMP: begin
          if (st.up) begin
            if (at_top) begin
              // top held for exactly this tick
              next_st.up    = (top == COUNT_BOTTOM);
              next_st.count = (top == COUNT_BOTTOM) ? st.count
                                                    : st.count - COUNT_ONE;
              next_st.cmp_a = st.cmp_a_buf;
              next_st.cmp_b = st.cmp_b_buf;
            end else begin
              next_st.count = st.count + COUNT_ONE;
            end
          end else if (st.count == COUNT_BOTTOM) begin
            next_st.up    = 1'b1;
            next_st.count = at_top ? st.count : st.count + COUNT_ONE;
          end else begin
            next_st.count = st.count - COUNT_ONE;
          end
        end
        default: next_st.count = st.count + COUNT_ONE;
      endcase
      next_st.wave_a = wave_next(st.wave_a, st.act_a, 1'b1, match_a, st.cmp_a,
                                 st.mode, st.count, st.up, top, tick);
      next_st.wave_b = wave_next(st.wave_b, st.act_b, 1'b0, match_b, st.cmp_b,
                                 st.mode, st.count, st.up, top, tick);
    end
    // register writes
    if (wr_go) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
      case (axi_req.awaddr)
        ADDR_CTRL: begin
          if (axi_req.wstrb[0]) begin
            next_st.mode  = axi_req.wdata[CTRL_MODE_LSB +: 3];
            next_st.run   = axi_req.wdata[CTRL_RUN];
            next_st.act_b = axi_req.wdata[CTRL_ACTB_LSB +: 2];
            next_st.act_a = axi_req.wdata[CTRL_ACTA_LSB +: 2];
          end
          if (axi_req.wstrb[1]) begin
            next_st.dir_a = axi_req.wdata[CTRL_DIRA];
            next_st.dir_b = axi_req.wdata[CTRL_DIRB];
          end
        end
        ADDR_CMPA: if (axi_req.wstrb[0]) begin
          next_st.cmp_a_buf = axi_req.wdata[7:0];
          if (!is_pwm)
            next_st.cmp_a = axi_req.wdata[7:0];
        end
        ADDR_CMPB: if (axi_req.wstrb[0]) begin
          next_st.cmp_b_buf = axi_req.wdata[7:0];
          if (!is_pwm)
            next_st.cmp_b = axi_req.wdata[7:0];
        end
        ADDR_COUNT: if (axi_req.wstrb[0]) begin
          next_st.count = axi_req.wdata[7:0];
          next_st.block = 1'b1;
        end
        ADDR_PRESC: if (axi_req.wstrb[0])
          next_st.presc = axi_req.wdata[7:0];
        default: ;
      endcase
    end else if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    // flags: write one clears, a set in the same cycle wins
    next_st.ovf    = st.ovf;
    next_st.flag_a = st.flag_a;
    next_st.flag_b = st.flag_b;
    if (wr_go && axi_req.awaddr == ADDR_FLAGS && axi_req.wstrb[0]) begin
      if (axi_req.wdata[FLAG_OVF])
        next_st.ovf = 1'b0;
      if (axi_req.wdata[FLAG_CMPA])
        next_st.flag_a = 1'b0;
      if (axi_req.wdata[FLAG_CMPB])
        next_st.flag_b = 1'b0;
    end
    if (tick) begin
      if (is_fast && at_top)
        next_st.ovf = 1'b1;
      else if (is_phase && !st.up && st.count == COUNT_ONE)
        next_st.ovf = 1'b1;
      else if (!is_pwm && st.count == COUNT_MAX)
        next_st.ovf = 1'b1;
    end
    if (match_a)
      next_st.flag_a = 1'b1;
    if (match_b)
      next_st.flag_b = 1'b1;
    // reads
    if (rd_go) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word;
      next_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st       <= '0;
      st.up    <= 1'b1;
      st.presc <= PRESC_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  always_comb begin
    // toggle code without the high bit, and on B in PWM, means disconnected
    conn_a = (st.act_a != ACT_OFF) &&
             !(is_pwm && st.act_a == ACT_TOGGLE && !st.mode[MODE_HIGH_BIT]);
    conn_b = (st.act_b != ACT_OFF) && !(is_pwm && st.act_b == ACT_TOGGLE);
    axi_rsp.awready   = wr_go;
    axi_rsp.wready    = wr_go;
    axi_rsp.bvalid    = st.bvalid;
    axi_rsp.bresp     = st.bresp;
    axi_rsp.arready   = rd_go;
    axi_rsp.rvalid    = st.rvalid;
    axi_rsp.rdata     = st.rdata;
    axi_rsp.rresp     = st.rresp;
    wave_out_a        = st.wave_a;
    wave_out_b        = st.wave_b;
    wave_out_a_pin    = conn_a && st.wave_a;
    wave_out_b_pin    = conn_b && st.wave_b;
    wave_out_a_pin_oe = st.dir_a;
    wave_out_b_pin_oe = st.dir_b;
    overflow_flag     = st.ovf;
    compare_a_flag    = st.flag_a;
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_ctc_clear;
    tick && st.mode == MODE_CTC && st.count == st.cmp_a |=> st.count == COUNT_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("ctc clear missed");

  property p_ctc_wrap;
    tick && st.mode == MODE_CTC && st.count == COUNT_MAX && st.cmp_a != COUNT_MAX
      |=> st.count == COUNT_BOTTOM && st.ovf;
  endproperty
  a_ctc_wrap: assert property (p_ctc_wrap) else $error("ctc wrap wrong");

  property p_flag_a;
    match_a |=> st.flag_a && compare_a_flag;
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("compare flag not set");

  property p_ctc_toggle;
    match_a && st.mode == MODE_CTC && st.act_a == ACT_TOGGLE
      |=> wave_out_a != $past(wave_out_a);
  endproperty
  a_ctc_toggle: assert property (p_ctc_toggle) else $error("toggle missed");

  property p_fast_top;
    tick && is_fast && at_top |=> st.count == COUNT_BOTTOM && overflow_flag;
  endproperty
  a_fast_top: assert property (p_fast_top) else $error("fast top wrong");

  property p_fast_bottom;
    tick && is_fast && at_top && st.act_a == ACT_CLEAR |=> wave_out_a;
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("bottom set missed");

  property p_phase_turn;
    tick && is_phase && st.up && at_top && top != COUNT_BOTTOM
      |=> !st.up && st.count == $past(st.count) - COUNT_ONE;
  endproperty
  a_phase_turn: assert property (p_phase_turn) else $error("phase turn wrong");

  property p_action_off;
    tick && st.act_a == ACT_OFF && !wr_go |=> $stable(wave_out_a);
  endproperty
  a_action_off: assert property (p_action_off) else $error("output moved");

  property p_buffered;
    is_pwm && !tick |=> $stable(st.cmp_a) && $stable(st.cmp_b);
  endproperty
  a_buffered: assert property (p_buffered) else $error("compare changed early");

endmodule // twm_timer

// ===== include/twm_pkg.sv
/*
  twm_pkg: constants, register map, bus carriers and state type of the
  8-bit timer waveform generator.
  Assumes: AXI4-Lite with 32-bit data, byte addresses, one word per register.
*/
package twm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CMPA  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CMPB  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PRESC = 8'h14;
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RUN      = 3;
  localparam int CTRL_ACTB_LSB = 4;
  localparam int CTRL_ACTA_LSB = 6;
  localparam int CTRL_DIRA     = 8;
  localparam int CTRL_DIRB     = 9;
  // flag positions
  localparam int FLAG_OVF  = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;
  // waveform mode codes
  localparam logic [2:0] MODE_NORMAL    = 3'h0;
  localparam logic [2:0] MODE_PHASE_MAX = 3'h1;
  localparam logic [2:0] MODE_CTC       = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX  = 3'h3;
  localparam logic [2:0] MODE_PHASE_CMP = 3'h5;
  localparam logic [2:0] MODE_FAST_CMP  = 3'h7;
  localparam int         MODE_HIGH_BIT  = 2;
  // output action codes
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;
  // counter extremes and reset values
  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_ONE    = 8'h01;
  localparam logic [7:0] PRESC_RESET  = 8'h00;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } twm_axi_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } twm_axi_rsp_t;

  typedef struct packed {
    logic [7:0]        count;
    logic              up;
    logic [7:0]        cmp_a_buf;
    logic [7:0]        cmp_b_buf;
    logic [7:0]        cmp_a;
    logic [7:0]        cmp_b;
    logic [2:0]        mode;
    logic [1:0]        act_a;
    logic [1:0]        act_b;
    logic              run;
    logic              dir_a;
    logic              dir_b;
    logic [7:0]        presc;
    logic [7:0]        div;
    logic              block;
    logic              ovf;
    logic              flag_a;
    logic              flag_b;
    logic              wave_a;
    logic              wave_b;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [DATA_W-1:0] rdata;
  } twm_state_t;
endpackage

// ===== dv/twm_load.sv
/*
  twm_load: external load on the two compare pins.
  Assumes: port pins with pull-ups, so an undriven pin reads high.
*/
`timescale 1ns/1ps
module twm_load (
  // pins from the timer
  input  wire logic pin_a,
  input  wire logic oe_a,
  input  wire logic pin_b,
  input  wire logic oe_b,
  // levels seen by the load
  output logic      level_a,
  output logic      level_b
);
  // pull-up wins only while the timer does not drive
  assign level_a = oe_a ? pin_a : 1'b1;
  assign level_b = oe_b ? pin_b : 1'b1;
endmodule // twm_load

// ===== dv/tb_top.sv
/*
  tb_top: self-checking bench of the timer waveform modes.
  Assumes: twm_pkg compiled first, prescale at reset value (tick each clock) except
  in the one prescaled scenario.
*/
`timescale 1ns/1ps
module tb_top;
  import twm_pkg::*;
  logic         clock;
  logic         rst_n;
  twm_axi_req_t req;
  twm_axi_rsp_t rsp;
  logic         wave_out_a;
  logic         wave_out_b;
  logic         pin_a;
  logic         oe_a;
  logic         pin_b;
  logic         oe_b;
  logic         overflow_flag;
  logic         compare_a_flag;
  logic         level_a;
  logic         level_b;
  int           error_cnt;
  int           n_tests;

  twm_timer u_twm_timer (
    .clock(clock), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
    .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .wave_out_a_pin(pin_a), .wave_out_a_pin_oe(oe_a),
    .wave_out_b_pin(pin_b), .wave_out_b_pin_oe(oe_b),
    .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag)
  );
  twm_load u_twm_load (
    .pin_a(pin_a), .oe_a(oe_a), .pin_b(pin_b), .oe_b(oe_b),
    .level_a(level_a), .level_b(level_b)
  );

  always #4 clock = ~clock;

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic limit(input int k, input int lim);
    if (k >= lim) begin
      error_cnt++;
      $display("wrong value handshake wait expected done seen timeout");
      close_out();
    end
  endtask

  // both channels offered together, released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    logic aw_ok;
    logic w_ok;
    @(posedge clock);
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    k = 0;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    // each channel released at its own ready
    do begin
      @(posedge clock);
      k++;
      if (rsp.awready === 1'b1)
        aw_ok = 1'b1;
      if (rsp.wready === 1'b1)
        w_ok = 1'b1;
      if (aw_ok)
        req.awvalid <= 1'b0;
      if (w_ok)
        req.wvalid <= 1'b0;
    end while (!(aw_ok && w_ok) && k < 50);
    limit(k, 50);
    do begin @(posedge clock); k++; end while (rsp.bvalid !== 1'b1 && k < 100);
    limit(k, 100);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clock);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    k = 0;
    do begin @(posedge clock); k++; end while (rsp.arready !== 1'b1 && k < 50);
    limit(k, 50);
    req.arvalid <= 1'b0;
    do begin @(posedge clock); k++; end while (rsp.rvalid !== 1'b1 && k < 100);
    limit(k, 100);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // both pin directions set to output
  function automatic logic [31:0] ctrl(logic [2:0] m, logic [1:0] ab, logic [1:0] aa,
                                       logic run);
    return {22'h0, 2'b11, aa, ab, run, m};
  endfunction

  // high steps per period: fast non-inverting, phase-correct non-inverting
  function automatic int fast_high(int c);
    return c + 1;
  endfunction

  function automatic int phase_high(int c);
    return 2 * c;
  endfunction

  // high cycles seen by the load on A and at output B
  task automatic measure(input int n, output int ha, output int hb);
    ha = 0;
    hb = 0;
    repeat (n) begin
      @(negedge clock);
      ha += int'(level_a === 1'b1);
      hb += int'(wave_out_b === 1'b1);
    end
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n, ca, cb, ha, hb, k, per, ps;
    clock = 1'b0;
    rst_n = 1'b0;
    req   = '0;
    error_cnt = 0;
    n_tests   = 0;
    void'($urandom(32'hED3ECA52));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("wave_a", wave_out_a, 0);
    chk("wave_b", wave_out_b, 0);
    chk("undriven_a", level_a, 1);
    chk("undriven_b", level_b, 1);
    rd(8'h3C, d, r);
    chk("bad_rresp", r, RESP_SLVERR);
    chk("bad_rdata", d, 0);
    wr(8'h3C, 32'h1, r);
    chk("bad_bresp", r, RESP_SLVERR);
    // clear-on-match square wave, period set by compare A
    n = $urandom_range(20, 3);
    wr(ADDR_CMPA, 32'(n), r);
    wr(ADDR_CTRL, ctrl(MODE_CTC, ACT_OFF, ACT_TOGGLE, 1'b1), r);
    repeat (4 * (n + 1)) @(posedge clock);
    measure(2 * (n + 1), ha, hb);
    chk("ctc_high_a", 32'(ha), 32'(n + 1));
    chk("ctc_b_idle", 32'(hb), 0);
    chk("ctc_flag_a", compare_a_flag, 1);
    chk("ctc_no_ovf", overflow_flag, 0);
    // compare moved below the count: match missed until wrap
    wr(ADDR_CTRL, ctrl(MODE_CTC, ACT_OFF, ACT_TOGGLE, 1'b0), r);
    wr(ADDR_COUNT, 32'hF0, r);
    wr(ADDR_FLAGS, 32'h7, r);
    wr(ADDR_CMPA, 32'h5, r);
    wr(ADDR_CTRL, ctrl(MODE_CTC, ACT_OFF, ACT_TOGGLE, 1'b1), r);
    k = 0;
    while (overflow_flag !== 1'b1 && k < 400) begin @(posedge clock); k++; end
    limit(k, 400);
    chk("miss_flag_a", compare_a_flag, 0);
    k = 0;
    while (compare_a_flag !== 1'b1 && k < 20) begin @(posedge clock); k++; end
    limit(k, 20);
    chk("flag_delay", 32'(k), 6);
    // duty table: fast then phase-correct, extremes first
    for (int i = 0; i < 6; i++) begin
      ca = (i % 3 == 0) ? 0 : (i % 3 == 1) ? 255 : $urandom_range(254, 1);
      cb = $urandom_range(255, 0);
      per = (i < 3) ? 256 : 510;
      wr(ADDR_CTRL, ctrl(i < 3 ? MODE_FAST_MAX : MODE_PHASE_MAX, ACT_SET, ACT_CLEAR, 1'b1), r);
      wr(ADDR_CMPA, 32'(ca), r);
      wr(ADDR_CMPB, 32'(cb), r);
      wr(ADDR_FLAGS, 32'h7, r);
      repeat (2 * per) @(posedge clock);
      chk("pwm_ovf", overflow_flag, 1);
      measure(per, ha, hb);
      if (i < 3) begin
        chk("fast_high_a", 32'(ha), 32'(fast_high(ca)));
        chk("fast_high_b", 32'(hb), 32'(256 - fast_high(cb)));
      end else begin
        chk("phase_high_a", 32'(ha), 32'(phase_high(ca)));
        chk("phase_high_b", 32'(hb), 32'(510 - phase_high(cb)));
      end
    end
    // prescaled fast PWM: every step lasts ps+1 clocks, compares held between ticks
    ps = $urandom_range(3, 1);
    ca = $urandom_range(254, 1);
    wr(ADDR_PRESC, 32'(ps), r);
    wr(ADDR_CTRL, ctrl(MODE_FAST_MAX, ACT_SET, ACT_CLEAR, 1'b1), r);
    wr(ADDR_CMPA, 32'(ca), r);
    repeat (2 * 256 * (ps + 1)) @(posedge clock);
    measure(256 * (ps + 1), ha, hb);
    chk("presc_high_a", 32'(ha), 32'(fast_high(ca) * (ps + 1)));
    // divider may run one lap before the first tick after this
    wr(ADDR_PRESC, 32'(PRESC_RESET), r);
    // fast PWM with top at compare A, A toggling
    n = $urandom_range(60, 10);
    wr(ADDR_CTRL, ctrl(MODE_FAST_CMP, ACT_TOGGLE, ACT_TOGGLE, 1'b1), r);
    wr(ADDR_CMPA, 32'(n), r);
    // old top may be below the count: allow a wrap before the buffer loads
    repeat (1024 + 4 * (n + 1)) @(posedge clock);
    measure(2 * (n + 1), ha, hb);
    chk("fast_tgl_a", 32'(ha), 32'(n + 1));
    chk("fast_pin_b", pin_b, 0);
    chk("fast_level_b", level_b, 0);
    wr(ADDR_CTRL, ctrl(MODE_FAST_MAX, ACT_OFF, ACT_TOGGLE, 1'b1), r);
    repeat (3) @(posedge clock);
    chk("fast_pin_a_off", pin_a, 0);
    // phase-correct with top at compare A
    ca = $urandom_range(100, 20);
    cb = $urandom_range(ca - 1, 1);
    wr(ADDR_CTRL, ctrl(MODE_PHASE_CMP, ACT_CLEAR, ACT_OFF, 1'b1), r);
    wr(ADDR_CMPA, 32'(ca), r);
    wr(ADDR_CMPB, 32'(cb), r);
    // entry may count down or wrap first; buffers load only at top
    repeat (1000 + 4 * ca) @(posedge clock);
    measure(2 * ca, ha, hb);
    chk("phase_top_b", 32'(hb), 32'(phase_high(cb)));
    wr(ADDR_CTRL, ctrl(MODE_PHASE_CMP, ACT_CLEAR, ACT_TOGGLE, 1'b1), r);
    repeat (3) @(posedge clock);
    // one toggle at each top: half of two toggle periods is high
    measure(4 * ca, ha, hb);
    chk("phase_tgl_a", 32'(ha), 32'(2 * ca));
    close_out();
  end
endmodule // tb_top
